/* logic/flag_bus_pkg.sv */
// Functional notes
// - internal flags are the bitwise AND of both channel copies, 16 bits.
// - shared vector feeds both channels; each channel gives only its own copy.
// - thirteen pins routable; in normal function element comes from internal flags.
// - a flag-configured pin loses its normal function, tied to one element.
// - input flag element takes filtered pin level, three clock filter.
// - output flag element from internal flags, driven onto the pin through one flop.
// - three pinless elements are internal exchange between channels only.
// - fixed mapping: 0-2 gp pins, 3-8 triggers, 9 irq, 10-11 analog, 12 debug.
// - only elements 12..3 have selectable source; top three internal, bottom three I/O.
// - source-select at 0x1C3, bits 12..3 read/write, bits 2..0 reserved.
// - reset loads debug and irq bits one, others zero, low reserved 111.
// - select 0 normal; select 1 direction 0 output; direction 1 input.
// - pin-linked flag inverted when its polarity bit is one.
package flag_bus_pkg;
   localparam int FlagWidth = 16;
   localparam int PinCount = 13;
   localparam int FilterCycles = 3;
   localparam int FilterTimeNs = 125;
   localparam int ClockMhz = 100;
   localparam int FilterCountCycles = (FilterTimeNs * ClockMhz + 999) / 1000;
   // register indices; byte address is four times the index
   localparam logic [11:0] DirIndex = 12'h1C1;
   localparam logic [11:0] PolIndex = 12'h1C2;
   localparam logic [11:0] SrcIndex = 12'h1C3;
   localparam logic [15:0] DirReset = 16'h1FFF;
   localparam logic [15:0] PolReset = 16'h0000;
   localparam logic [15:0] SrcReset = 16'h1207;
   localparam logic [15:0] SrcWritable = 16'h1FF8;
   localparam logic [15:0] PinMask = 16'h1FFF;
   localparam logic [15:0] FixedIoMask = 16'h0007;
   typedef struct packed {
      logic [31:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_t;
   typedef struct packed {
      logic [PinCount-1:0] out;
      logic [PinCount-1:0] oe;
   } pin_drive_t;
   function automatic logic [31:0] regAddr(input logic [11:0] idx);
      regAddr = {18'h00000, idx, 2'h0};
   endfunction : regAddr
endpackage : flag_bus_pkg

/* logic/glitch_filter.sv */
module glitch_filter
   import flag_bus_pkg::*;
#(
   parameter int Width = PinCount,
   parameter int Stable = FilterCycles
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [Width-1:0] level,
   output logic [Width-1:0] filtered
);
   logic [Width-1:0] prev_q;
   logic [Width-1:0][1:0] count_q;
   logic [Width-1:0] filtered_q;
   assign filtered = filtered_q;
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prev_q <= '0;
         count_q <= '0;
         filtered_q <= '0;
      end else begin
         for (int i = 0; i < Width; i++) begin
            prev_q[i] <= level[i];
            if (level[i] != prev_q[i]) begin
               count_q[i] <= 2'h1;
            end else if (count_q[i] < 2'(Stable)) begin
               count_q[i] <= count_q[i] + 2'h1;
            end
            // level seen on Stable consecutive samples before it is taken
            if (level[i] == prev_q[i] && count_q[i] >= 2'(Stable - 1)) begin
               filtered_q[i] <= level[i];
            end
         end
      end
   end
endmodule : glitch_filter

/* logic/flag_regs.sv */
module flag_regs
   import flag_bus_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire apb_req_t req,
   output apb_rsp_t rsp,
   input wire logic [FlagWidth-1:0] flagView,
   output logic [FlagWidth-1:0] srcSel,
   output logic [FlagWidth-1:0] dirSel,
   output logic [FlagWidth-1:0] polSel
);
   localparam logic [11:0] ViewIndex = 12'h1C4;
   logic [FlagWidth-1:0] src_q, dir_q, pol_q;
   apb_rsp_t rsp_q;
   logic accEn, wrEn, rdEn, hit;
   assign srcSel = src_q;
   assign dirSel = dir_q;
   assign polSel = pol_q;
   assign rsp = rsp_q;
   // one wait state: pready stands for the access phase's second edge
   assign accEn = req.psel && req.penable && !rsp_q.pready;
   // write commits only at the edge where the master sees pready high
   assign wrEn = req.psel && req.penable && req.pwrite && rsp_q.pready;
   assign rdEn = accEn && !req.pwrite;
   assign hit = req.paddr == regAddr(SrcIndex) || req.paddr == regAddr(DirIndex)
      || req.paddr == regAddr(PolIndex) || req.paddr == regAddr(ViewIndex);
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         src_q <= SrcReset;
         dir_q <= DirReset;
         pol_q <= PolReset;
      end else if (wrEn) begin
         if (req.paddr == regAddr(SrcIndex)) begin
            src_q <= (req.pwdata[15:0] & SrcWritable) | (SrcReset & ~SrcWritable);
         end
         if (req.paddr == regAddr(DirIndex)) begin
            dir_q <= req.pwdata[15:0] & PinMask;
         end
         if (req.paddr == regAddr(PolIndex)) begin
            pol_q <= req.pwdata[15:0] & PinMask;
         end
      end
   end
   // response; unmapped address gives pslverr and zero data
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rsp_q <= '0;
      end else begin
         rsp_q.pready <= accEn;
         rsp_q.pslverr <= accEn && !hit;
         rsp_q.prdata <= '0;
         if (rdEn) begin
            if (req.paddr == regAddr(SrcIndex)) rsp_q.prdata <= {16'h0000, src_q};
            if (req.paddr == regAddr(DirIndex)) rsp_q.prdata <= {16'h0000, dir_q};
            if (req.paddr == regAddr(PolIndex)) rsp_q.prdata <= {16'h0000, pol_q};
            if (req.paddr == regAddr(ViewIndex)) rsp_q.prdata <= {16'h0000, flagView};
         end
      end
   end
endmodule : flag_regs

/* logic/flag_bus_router.sv */
// Added by the designer: the APB interface to the registers.
module flag_bus_router
   import flag_bus_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire apb_req_t apbReq,
   output apb_rsp_t apbRsp,
   input wire logic [FlagWidth-1:0] channelFlags0,
   input wire logic [FlagWidth-1:0] channelFlags1,
   output logic [FlagWidth-1:0] flagBus,
   input wire logic [PinCount-1:0] pinIn,
   output logic [PinCount-1:0] pinOut,
   output logic [PinCount-1:0] pinOe,
   output logic [PinCount-1:0] pinFlagMode,
   output logic [PinCount-1:0] pinFlagPolarity
);
   logic [FlagWidth-1:0] srcSel, dirSel, polSel;
   logic [FlagWidth-1:0] intFlags, effSrc, busD;
   logic [PinCount-1:0] pinSync1_q, pinSync2_q, pinFilt;
   logic [FlagWidth-1:0] flagBus_q;
   pin_drive_t drive_q;
   logic [PinCount-1:0] mode_q, pol_q;
   apb_rsp_t rsp;

   flag_regs u_regs (
      .clock(clock),
      .rst_n(rst_n),
      .req(apbReq),
      .rsp(rsp),
      .flagView(flagBus_q),
      .srcSel(srcSel),
      .dirSel(dirSel),
      .polSel(polSel)
   );

   // pins come from outside: two-stage sync
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pinSync1_q <= '0;
         pinSync2_q <= '0;
      end else begin
         pinSync1_q <= pinIn;
         pinSync2_q <= pinSync1_q;
      end
   end

   glitch_filter u_filt (
      .clock(clock),
      .rst_n(rst_n),
      .level(pinSync2_q),
      .filtered(pinFilt)
   );

   assign intFlags = channelFlags0 & channelFlags1;
   // bottom three always I/O, top three never
   assign effSrc = (srcSel & SrcWritable) | FixedIoMask;

   always_comb begin
      busD = intFlags;
      for (int i = 0; i < PinCount; i++) begin
         if (effSrc[i] && dirSel[i]) begin
            busD[i] = pinFilt[i] ^ polSel[i];
         end
      end
   end

   // shared vector back to both channels
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         flagBus_q <= '0;
      end else begin
         flagBus_q <= busD;
      end
   end

   // pin i tied to element i; output drive
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         drive_q <= '0;
         mode_q <= '0;
         pol_q <= '0;
      end else begin
         for (int i = 0; i < PinCount; i++) begin
            drive_q.out[i] <= intFlags[i] ^ polSel[i];
            drive_q.oe[i] <= effSrc[i] && !dirSel[i];
            mode_q[i] <= effSrc[i];
            pol_q[i] <= polSel[i];
         end
      end
   end

   assign flagBus = flagBus_q;
   assign pinOut = drive_q.out;
   assign pinOe = drive_q.oe;
   assign pinFlagMode = mode_q;
   assign pinFlagPolarity = pol_q;
   // answer is already a flop in the register block; a second stage would
   // delay pready past the held access and make it pulse twice
   assign apbRsp = rsp;
endmodule : flag_bus_router

/* verification/chan_pair_model.sv */
module chan_pair_model
   import flag_bus_pkg::*;
(
   input wire logic clock,
   input wire logic [FlagWidth-1:0] want,
   output logic [FlagWidth-1:0] copy0,
   output logic [FlagWidth-1:0] copy1
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [FlagWidth-1:0] r;
   int seed = 5;
   // copies differ, only the AND carries want
   always @(posedge clock) begin
      r = $random(seed);
      copy0 <= want | r;
      copy1 <= want | ~r;
   end
endmodule : chan_pair_model

/* verification/flag_bus_router_props.sv */
module flag_bus_router_props
   import flag_bus_pkg::*;
(
   input wire logic clock,
   input wire logic rst_n,
   input wire apb_req_t apbReq,
   input wire apb_rsp_t apbRsp,
   input wire logic [FlagWidth-1:0] channelFlags0,
   input wire logic [FlagWidth-1:0] channelFlags1,
   input wire logic [FlagWidth-1:0] flagBus,
   input wire logic [PinCount-1:0] pinOut,
   input wire logic [PinCount-1:0] pinOe,
   input wire logic [PinCount-1:0] pinFlagMode,
   input wire logic [PinCount-1:0] pinFlagPolarity
);
   timeunit 1ns;
   timeprecision 1ps;
   // combined copies, seen one cycle later on the bus
   wire logic [FlagWidth-1:0] intF = channelFlags0 & channelFlags1;
   wire logic [PinCount-1:0] intLow = intF[PinCount-1:0];
   wire logic [PinCount-1:0] inMode = pinFlagMode & ~pinOe;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   ready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready) else $error("pready held");
   ready_cause_a: assert property (apbRsp.pready |-> apbReq.psel && apbReq.penable)
      else $error("pready without access");
   err_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready) else $error("lone pslverr");
   ready_bound_a: assert property ($rose(apbReq.penable) && apbReq.psel |-> ##[1:4] apbRsp.pready)
      else $error("no answer");
   internal_top_a: assert property ($past(rst_n) |-> ((flagBus ^ $past(intF)) & 16'hE000) == 0)
      else $error("top flags wrong");
   gp_fixed_a: assert property ($past(rst_n) |-> &pinFlagMode[2:0])
      else $error("low pins not flags");
   oe_mode_a: assert property ((pinOe & ~pinFlagMode) == 0) else $error("oe in normal mode");
   out_drive_a: assert property ($past(rst_n) && $stable(pinFlagPolarity)
      |-> pinOut == ($past(intLow) ^ pinFlagPolarity)) else $error("pin drive wrong");
   bus_path_a: assert property ($past(rst_n) && $stable(inMode)
      |-> ((flagBus[PinCount-1:0] ^ $past(intLow)) & ~inMode) == 0) else $error("bus wrong");
   cover property (apbRsp.pslverr);
   cover property (pinOe != 0);
   cover property (inMode != 0);
endmodule : flag_bus_router_props

/* verification/tb.sv */
module tb
   import flag_bus_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0;
   logic rst_n = 0;
   apb_req_t req = '0;
   apb_rsp_t rsp;
   logic [15:0] want = '0, ch0, ch1, bus, w, p;
   logic [12:0] pinIn = '0, pinOut, pinOe, mode, pol, q;
   logic [31:0] rd;
   logic bad;
   int err_count = 0, tests_run = 0, seed = 68;
   always #5 clock = ~clock;
   chan_pair_model chan_u (.clock(clock), .want(want), .copy0(ch0), .copy1(ch1));
   flag_bus_router dut_u (.clock(clock), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp),
      .channelFlags0(ch0), .channelFlags1(ch1), .flagBus(bus), .pinIn(pinIn), .pinOut(pinOut),
      .pinOe(pinOe), .pinFlagMode(mode), .pinFlagPolarity(pol));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // one apb transfer, held until pready
   task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
      @(posedge clock);
      req.penable <= 1'b1;
      // only the watchdog ends a wait that never gets an answer
      do begin
         @(posedge clock);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      bad = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb
   function automatic logic [12:0] pinExp(input logic [12:0] v, input logic [12:0] pl);
      return v ^ pl;
   endfunction : pinExp
   task test_done;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      apb(1'b0, 32'h0000070C, 32'h0);
      chk(rd, 32'h00001207);
      apb(1'b0, 32'h00000704, 32'h0);
      chk(rd, 32'h00001FFF);
      apb(1'b1, 32'h0000070C, 32'hFFFFFFFF);
      apb(1'b0, 32'h0000070C, 32'h0);
      chk(rd, 32'h00001FFF);
      // unmapped place refused
      apb(1'b0, 32'h00000800, 32'h0);
      chk({bad, rd[30:0]}, 32'h80000000);
      apb(1'b1, 32'h0000070C, 32'h0);
      repeat (8) begin
         w = $random(seed);
         want <= w;
         repeat (4) @(posedge clock);
         chk(bus[15:3], w[15:3]);
      end
      chk(mode, 13'h0007);
      apb(1'b1, 32'h00000704, 32'h0);
      apb(1'b1, 32'h0000070C, 32'h00001FF8);
      p = $random(seed);
      apb(1'b1, 32'h00000708, {16'h0000, p});
      repeat (8) begin
         w = $random(seed);
         want <= w;
         repeat (4) @(posedge clock);
         chk(pinOut, pinExp(w[12:0], p[12:0]));
         chk(bus, w);
         chk(pinOe, 13'h1FFF);
      end
      chk(mode, 13'h1FFF);
      chk(pol, p[12:0]);
      apb(1'b1, 32'h00000704, 32'h00001FFF);
      repeat (8) begin
         q = $random(seed);
         pinIn <= q;
         repeat (10) @(posedge clock);
         chk(bus[12:0], pinExp(q, p[12:0]));
         pinIn <= ~q;
         repeat (2) @(posedge clock);
         pinIn <= q;
         repeat (8) begin
            @(posedge clock);
            chk(bus[12:0], pinExp(q, p[12:0]));
         end
      end
      // shared vector read back over the register bus
      apb(1'b0, 32'h00000710, 32'h0);
      chk(rd[12:0], pinExp(q, p[12:0]));
      test_done;
   end
   initial begin
      #300us;
      err_count++;
      test_done;
   end
endmodule : tb
bind flag_bus_router flag_bus_router_props props_u (.clock(clock), .rst_n(rst_n),
   .apbReq(apbReq), .apbRsp(apbRsp), .channelFlags0(channelFlags0), .channelFlags1(channelFlags1),
   .flagBus(flagBus), .pinOut(pinOut), .pinOe(pinOe), .pinFlagMode(pinFlagMode),
   .pinFlagPolarity(pinFlagPolarity));
